/* File: hw/hub_config_source_select.sv */
// Configuration source selection, command routing and strap handling
`timescale 1ns/1ps
`default_nettype none
module hub_config_source_select
  import hub_cfg_pkg::*;
#(
  // Arbitrary value standing in for the ROM signature
  parameter logic [31:0] ROM_SIGNATURE = 32'h5ac3963c
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        romValid,
  input  wire logic [7:0]  romData,
  input  wire logic        smbusPresent,
  input  wire smb_wr_t     smbWr,
  input  wire cmd_req_t    smbOtpCmd,
  input  wire cmd_req_t    usbCmd,
  input  wire logic        hubAttached,
  input  wire logic        suspend,
  input  wire logic        rateStrapIn,
  input  wire logic        rateStrapFunc,
  output logic             romReq,
  output logic [15:0]      romAddr,
  output cfg_src_t         cfgSource,
  output logic             cfgDone,
  output logic             execExternal,
  output logic [15:0]      execStartAddr,
  output smb_wr_t          extWr,
  output logic             vendorMsgEnabled,
  output logic             ecEnabled,
  output logic             specialResume,
  output logic             hubResetReq,
  output logic             i2cPass,
  output logic             spiPass,
  output cmd_req_t         i2cOut,
  output cmd_req_t         spiOut,
  output otp_req_t         otpOut,
  output otp_mode_t        otpMode,
  output logic             spiFast,
  output logic [6:0]       spiRateMhz,
  output logic             rateStrapOut,
  output logic             rateStrapOe,
  output logic             rateStrapPull
);

  typedef enum logic [2:0] {
    ST_PROBE = 3'b000,
    ST_WAIT  = 3'b001,
    ST_SMB   = 3'b010,
    ST_SOC   = 3'b011,
    ST_DONE  = 3'b100
  } seq_state_t;

  seq_state_t  state;
  seq_state_t  next_state;
  logic [1:0]  idx;
  logic [1:0]  next_idx;
  logic        sigBad;
  logic        next_sigBad;
  logic        badNow;
  logic [7:0]  sigByte;
  cfg_src_t    next_cfgSource;
  logic        next_cfgDone;
  logic        next_romReq;
  logic [15:0] next_romAddr;
  logic        next_execExternal;
  logic [15:0] next_execStartAddr;
  logic        rateCapValid;

  assign sigByte = ROM_SIGNATURE[8 * (3 - idx) +: 8];

  always_comb
  begin
    next_state         = state;
    next_idx           = idx;
    next_sigBad        = sigBad;
    next_cfgSource     = cfgSource;
    next_cfgDone       = cfgDone;
    next_romReq        = 1'b0;
    next_romAddr       = romAddr;
    next_execExternal  = execExternal;
    next_execStartAddr = execStartAddr;
    badNow             = sigBad | (romData != sigByte);
    unique case (state)
      ST_PROBE:
      begin
        next_romReq  = 1'b1;
        next_romAddr = SIG_ADDR + {14'h0000, idx};
        next_state   = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (romValid)
        begin
          next_sigBad = badNow;
          if (idx == SIG_LAST)
          begin
            if (!badNow)
            begin
              next_cfgSource     = SRC_SPI;
              next_cfgDone       = 1'b1;
              next_execExternal  = 1'b1;
              next_execStartAddr = EXEC_ADDR;
              next_state         = ST_DONE;
            end
            else
            begin
              next_state = ST_SMB;
            end
          end
          else
          begin
            next_idx   = idx + 2'h1;
            next_state = ST_PROBE;
          end
        end
      end
      ST_SMB:
      begin
        if (smbusPresent)
        begin
          next_cfgSource = SRC_SMBUS;
          next_state     = ST_SOC;
        end
        else
        begin
          next_cfgSource = SRC_DEFAULT;
          next_cfgDone   = 1'b1;
          next_state     = ST_DONE;
        end
      end
      ST_SOC:
      begin
        // No timeout: the host may take as long as it likes
        if (smbWr.valid && smbWr.addr == END_CFG_REG)
        begin
          next_cfgDone = 1'b1;
          next_state   = ST_DONE;
        end
      end
      ST_DONE:
      begin
        next_state = ST_DONE;
      end
      default:
      begin
        next_state = ST_PROBE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state         <= ST_PROBE;
      idx           <= 2'h0;
      sigBad        <= 1'b0;
      cfgSource     <= SRC_NONE;
      cfgDone       <= 1'b0;
      romReq        <= 1'b0;
      romAddr       <= 16'h0000;
      execExternal  <= 1'b0;
      execStartAddr <= 16'h0000;
    end
    else
    begin
      state         <= next_state;
      idx           <= next_idx;
      sigBad        <= next_sigBad;
      cfgSource     <= next_cfgSource;
      cfgDone       <= next_cfgDone;
      romReq        <= next_romReq;
      romAddr       <= next_romAddr;
      execExternal  <= next_execExternal;
      execStartAddr <= next_execStartAddr;
    end
  end

  // Command routing
  smb_wr_t   next_extWr;
  logic      next_ecEnabled;
  logic      next_specialResume;
  logic      next_hubResetReq;
  logic      next_i2cPass;
  logic      next_spiPass;
  cmd_req_t  next_i2cOut;
  cmd_req_t  next_spiOut;
  otp_req_t  next_otpOut;
  otp_mode_t next_otpMode;
  logic      smbOtpOk;

  // SMBus has OTP access only while SMBus is the configuration source
  assign smbOtpOk = smbOtpCmd.valid && cfgSource == SRC_SMBUS;

  always_comb
  begin
    next_extWr         = '0;
    next_ecEnabled     = ecEnabled;
    next_specialResume = specialResume;
    next_hubResetReq   = 1'b0;
    next_i2cPass       = i2cPass;
    next_spiPass       = spiPass;
    next_i2cOut        = '0;
    next_spiOut        = '0;
    next_otpOut        = '0;
    next_otpMode       = otpMode;
    if (state == ST_SOC && smbWr.valid && smbWr.addr != END_CFG_REG
        && !hubAttached)
    begin
      next_extWr = smbWr;
    end
    if (usbCmd.valid)
    begin
      unique case (usbCmd.op)
        CMD_EC_ON:     next_ecEnabled = vendorMsgEnabled;
        CMD_EC_OFF:    next_ecEnabled = ecEnabled & ~vendorMsgEnabled;
        CMD_SRES_ON:   next_specialResume = vendorMsgEnabled;
        CMD_SRES_OFF:
          next_specialResume = specialResume & ~vendorMsgEnabled;
        CMD_HUB_RESET: next_hubResetReq = vendorMsgEnabled;
        CMD_I2C_ENTER: next_i2cPass = 1'b1;
        CMD_I2C_LEAVE: next_i2cPass = 1'b0;
        CMD_I2C_WRITE, CMD_I2C_READ, CMD_I2C_START, CMD_I2C_STOP:
        begin
          next_i2cOut       = usbCmd;
          next_i2cOut.valid = i2cPass;
        end
        CMD_SPI_ENTER: next_spiPass = 1'b1;
        CMD_SPI_LEAVE: next_spiPass = 1'b0;
        CMD_SPI_WRITE, CMD_SPI_READ:
        begin
          next_spiOut       = usbCmd;
          next_spiOut.valid = spiPass;
        end
        CMD_OTP_RESET, CMD_OTP_MODE, CMD_OTP_RMODE,
        CMD_OTP_PROG, CMD_OTP_STAT, CMD_OTP_CTRL:
        begin
          // USB side has no mode choice at all
          next_otpMode = OTP_SINGLE;
          next_otpOut  = '{valid: 1'b1, op: usbCmd.op, mode: OTP_SINGLE};
        end
        default:
        begin
        end
      endcase
    end
    else if (smbOtpOk && smbOtpCmd.op >= CMD_OTP_RESET
             && smbOtpCmd.op <= CMD_OTP_CTRL)
    begin
      if (smbOtpCmd.op == CMD_OTP_MODE)
      begin
        next_otpMode = otp_mode_t'(smbOtpCmd.arg[1:0]);
      end
      next_otpOut = '{valid: 1'b1, op: smbOtpCmd.op, mode: next_otpMode};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      extWr            <= '0;
      vendorMsgEnabled <= VENDOR_MSG_RESET;
      ecEnabled        <= 1'b0;
      specialResume    <= 1'b0;
      hubResetReq      <= 1'b0;
      i2cPass          <= 1'b0;
      spiPass          <= 1'b0;
      i2cOut           <= '0;
      spiOut           <= '0;
      otpOut           <= '0;
      otpMode          <= OTP_SINGLE;
    end
    else
    begin
      extWr            <= next_extWr;
      vendorMsgEnabled <= vendorMsgEnabled;
      ecEnabled        <= next_ecEnabled;
      specialResume    <= next_specialResume;
      hubResetReq      <= next_hubResetReq;
      i2cPass          <= next_i2cPass;
      spiPass          <= next_spiPass;
      i2cOut           <= next_i2cOut;
      spiOut           <= next_spiOut;
      otpOut           <= next_otpOut;
      otpMode          <= next_otpMode;
    end
  end

  // Board must not drive the strap; pulled in reset, then driven from rateStrapFunc or parked in suspend
  strap_pin #(
    .SUSPEND_PARK (1'b1)
  ) u_rate_strap (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .padIn    (rateStrapIn),
    .funcOut  (rateStrapFunc),
    .suspend  (suspend),
    .padOut   (rateStrapOut),
    .padOe    (rateStrapOe),
    .pullEn   (rateStrapPull),
    .capVal   (spiFast),
    .capValid (rateCapValid)
  );

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      spiRateMhz <= SPI_SLOW_MHZ;
    end
    else
    begin
      // Follows the strap one cycle late; settles one cycle after the first ROM probe request is raised
      spiRateMhz <= spiFast ? SPI_FAST_MHZ : SPI_SLOW_MHZ;
    end
  end

  a_probe_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |=> romReq && romAddr == SIG_ADDR)
    else $error("ROM probe not first");

  a_spi_exclusive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfgSource == SRC_SPI |-> !extWr.valid
      && (!otpOut.valid || otpOut.mode == OTP_SINGLE))
    else $error("SMBus acted with ROM present");

  a_sig_exec: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == ST_WAIT && romValid && idx == SIG_LAST && !badNow |=>
      execExternal && execStartAddr == EXEC_ADDR && cfgDone)
    else $error("valid signature not honoured");

  a_smb_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == ST_SMB |=> cfgSource == (smbusPresent ? SRC_SMBUS
      : SRC_DEFAULT))
    else $error("wrong fallback source");

  a_default_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == ST_SMB && !smbusPresent |=> cfgDone ##1 cfgDone)
    else $error("default path not done");

  a_soc_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == ST_SOC && !(smbWr.valid && smbWr.addr == END_CFG_REG)
      |=> !cfgDone)
    else $error("config ended without end write");

  a_vendor_msg_reset: assert property (@(posedge sys_clk)
    !rst_n |=> vendorMsgEnabled)
    else $error("vendor messages off after reset");

  a_hub_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    usbCmd.valid && usbCmd.op == CMD_HUB_RESET |=> hubResetReq)
    else $error("hub reset not issued");

  a_pass_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (i2cOut.valid |-> $past(i2cPass)) and
    (spiOut.valid |-> $past(spiPass)))
    else $error("pass-through forwarded while closed");

  a_otp_usb_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
    usbCmd.valid && usbCmd.op >= CMD_OTP_RESET && usbCmd.op <= CMD_OTP_CTRL
      |=> otpOut.valid && otpOut.mode == OTP_SINGLE)
    else $error("USB OTP not single-ended");

  a_otp_smb_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    smbOtpOk && !usbCmd.valid && smbOtpCmd.op == CMD_OTP_MODE
      |=> otpMode == otp_mode_t'($past(smbOtpCmd.arg[1:0])))
    else $error("SMBus OTP mode not applied");

  a_smb_attach: assert property (@(posedge sys_clk) disable iff (!rst_n)
    extWr.valid |-> !$past(hubAttached))
    else $error("config write after attach");

  a_rate_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rateCapValid && $past(rateCapValid) |->
      spiRateMhz == (spiFast ? SPI_FAST_MHZ : SPI_SLOW_MHZ))
    else $error("SPI rate mismatch");

  c_spi_found: cover property (@(posedge sys_clk) disable iff (!rst_n)
    cfgSource == SRC_SPI && cfgDone);
  c_smb_done: cover property (@(posedge sys_clk) disable iff (!rst_n)
    cfgSource == SRC_SMBUS && $rose(cfgDone));
  c_default: cover property (@(posedge sys_clk) disable iff (!rst_n)
    cfgSource == SRC_DEFAULT && cfgDone);
  c_park_low: cover property (@(posedge sys_clk) disable iff (!rst_n)
    suspend && !spiFast && rateStrapOe);

endmodule // hub_config_source_select
`default_nettype wire

/* File: hw/hub_cfg_pkg.sv */
// Shared constants and types for the hub configuration source selector
package hub_cfg_pkg;

  localparam logic [15:0] SIG_ADDR       = 16'hfffa;
  localparam logic [15:0] EXEC_ADDR      = 16'h0000;
  localparam logic [1:0]  SIG_LAST       = 2'h3;
  localparam logic [7:0]  END_CFG_REG    = 8'hff;
  localparam logic [6:0]  SPI_SLOW_MHZ   = 7'h1e;
  localparam logic [6:0]  SPI_FAST_MHZ   = 7'h3c;
  localparam logic        STRAP_RESET    = 1'h0;
  localparam logic        VENDOR_MSG_RESET = 1'h1;

  typedef enum logic [1:0] {
    SRC_NONE    = 2'b00,
    SRC_SPI     = 2'b01,
    SRC_SMBUS   = 2'b10,
    SRC_DEFAULT = 2'b11
  } cfg_src_t;

  typedef enum logic [1:0] {
    OTP_SINGLE      = 2'b00,
    OTP_DIFF        = 2'b01,
    OTP_REDUND      = 2'b10,
    OTP_DIFF_REDUND = 2'b11
  } otp_mode_t;

  typedef enum logic [4:0] {
    CMD_NOP       = 5'h00,
    CMD_EC_ON     = 5'h01,
    CMD_EC_OFF    = 5'h02,
    CMD_SRES_ON   = 5'h03,
    CMD_SRES_OFF  = 5'h04,
    CMD_HUB_RESET = 5'h05,
    CMD_I2C_ENTER = 5'h06,
    CMD_I2C_LEAVE = 5'h07,
    CMD_I2C_WRITE = 5'h08,
    CMD_I2C_READ  = 5'h09,
    CMD_I2C_START = 5'h0a,
    CMD_I2C_STOP  = 5'h0b,
    CMD_SPI_ENTER = 5'h0c,
    CMD_SPI_LEAVE = 5'h0d,
    CMD_SPI_WRITE = 5'h0e,
    CMD_SPI_READ  = 5'h0f,
    CMD_OTP_RESET = 5'h10,
    CMD_OTP_MODE  = 5'h11,
    CMD_OTP_RMODE = 5'h12,
    CMD_OTP_PROG  = 5'h13,
    CMD_OTP_STAT  = 5'h14,
    CMD_OTP_CTRL  = 5'h15
  } cmd_t;

  typedef struct packed {
    logic       valid;
    cmd_t       op;
    logic [7:0] arg;
  } cmd_req_t;

  typedef struct packed {
    logic      valid;
    cmd_t      op;
    otp_mode_t mode;
  } otp_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } smb_wr_t;

endpackage

/* File: hw/strap_pin.sv */
// One configuration strap pin: capture at reset release, then output
`timescale 1ns/1ps
`default_nettype none
module strap_pin
  import hub_cfg_pkg::*;
#(
  parameter bit SUSPEND_PARK = 1'b0
)
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic padIn,
  input  wire logic funcOut,
  input  wire logic suspend,
  output logic      padOut,
  output logic      padOe,
  output logic      pullEn,
  output logic      capVal,
  output logic      capValid
);

  logic next_padOut;
  logic next_padOe;
  logic next_capVal;

  always_comb
  begin
    // First cycle after release samples the pin; value frozen afterwards
    next_capVal = capValid ? capVal : padIn;
    next_padOut = funcOut;
    next_padOe  = 1'b1;
    if (SUSPEND_PARK && suspend)
    begin
      // Parked low only when strapped low, so a pull-up is never fought
      next_padOut = 1'b0;
      next_padOe  = ~next_capVal;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      padOut   <= 1'b0;
      padOe    <= 1'b0;
      pullEn   <= 1'b1;
      capVal   <= STRAP_RESET;
      capValid <= 1'b0;
    end
    else
    begin
      padOut   <= next_padOut;
      padOe    <= next_padOe;
      pullEn   <= 1'b1;
      capVal   <= next_capVal;
      capValid <= 1'b1;
    end
  end

  a_strap_hiz_reset: assert property (@(posedge sys_clk)
    !rst_n |=> !padOe && !capValid)
    else $error("strap driven out of reset");

  a_strap_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !capValid |=> capVal == $past(padIn))
    else $error("strap not captured at release");

  a_strap_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    capValid |=> $stable(capVal))
    else $error("captured strap changed");

  a_strap_park: assert property (@(posedge sys_clk) disable iff (!rst_n)
    SUSPEND_PARK && capValid && suspend |=>
      (capVal ? !padOe : (padOe && !padOut)))
    else $error("strap suspend drive wrong");

  a_pull_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
    capValid |-> pullEn)
    else $error("strap pull dropped");

endmodule // strap_pin
`default_nettype wire

/* File: dv/rom_model.sv */
// Behavioural SPI ROM that answers the signature probe of the selector
`timescale 1ns/1ps
`default_nettype none
module rom_model
#(
  parameter logic [31:0] SIG = 32'h00000000
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        romReq,
  input  wire logic [15:0] romAddr,
  input  wire logic        present,
  input  wire logic [3:0]  lat,
  output logic             romValid,
  output logic [7:0]       romData
);
  logic [15:0] addr;

  initial
  begin
    romValid = 1'b0;
    romData  = 8'h00;
    forever
    begin
      @(posedge sys_clk);
      if (rst_n === 1'b1 && romReq === 1'b1)
      begin
        addr = romAddr;
        repeat (lat) @(posedge sys_clk);
        #10;
        romValid = 1'b1;
        // A blank or missing part reads all ones, so the probe still ends
        if (present && addr >= 16'hfffa && addr <= 16'hfffd)
          romData = SIG[8 * (16'hfffd - addr) +: 8];
        else
          romData = 8'hff;
        @(posedge sys_clk);
        #10;
        romValid = 1'b0;
        // Data is no longer held; a stale byte must not pass for a valid one
        romData = ~romData;
      end
    end
  end
endmodule // rom_model
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the configuration source selector
`timescale 1ns/1ps
`default_nettype none
module testbench
  import hub_cfg_pkg::*;
;
  // Arbitrary signature value, shared by the ROM model and the design
  localparam logic [31:0] SIG = 32'h1e2d3c4b;
  logic        sys_clk, rst_n, romValid, smbusPresent, hubAttached;
  logic        suspend, rateStrapIn, rateStrapFunc, romPresent;
  logic        romReq, cfgDone, execExternal, vendorMsgEnabled, ecEnabled;
  logic        specialResume, hubResetReq, i2cPass, spiPass, spiFast;
  logic        rateStrapOut, rateStrapOe, rateStrapPull;
  logic [3:0]  romLat;
  logic [7:0]  romData;
  logic [15:0] romAddr, execStartAddr;
  logic [6:0]  spiRateMhz;
  smb_wr_t     smbWr, extWr;
  cmd_req_t    smbOtpCmd, usbCmd, i2cOut, spiOut;
  otp_req_t    otpOut;
  otp_mode_t   otpMode;
  cfg_src_t    cfgSource;
  int          failCount, nChecks, cycles;
  logic [15:0] addrs[$];
  cmd_t        i2cOps[4] = '{CMD_I2C_WRITE, CMD_I2C_READ, CMD_I2C_START,
                             CMD_I2C_STOP};
  cmd_t        otpOps[6] = '{CMD_OTP_RESET, CMD_OTP_MODE, CMD_OTP_RMODE,
                             CMD_OTP_PROG, CMD_OTP_STAT, CMD_OTP_CTRL};

  hub_config_source_select #(.ROM_SIGNATURE(SIG)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .romValid(romValid),
    .romData(romData), .smbusPresent(smbusPresent), .smbWr(smbWr),
    .smbOtpCmd(smbOtpCmd), .usbCmd(usbCmd), .hubAttached(hubAttached),
    .suspend(suspend), .rateStrapIn(rateStrapIn),
    .rateStrapFunc(rateStrapFunc), .romReq(romReq), .romAddr(romAddr),
    .cfgSource(cfgSource), .cfgDone(cfgDone), .execExternal(execExternal),
    .execStartAddr(execStartAddr), .extWr(extWr),
    .vendorMsgEnabled(vendorMsgEnabled), .ecEnabled(ecEnabled),
    .specialResume(specialResume), .hubResetReq(hubResetReq),
    .i2cPass(i2cPass), .spiPass(spiPass), .i2cOut(i2cOut),
    .spiOut(spiOut), .otpOut(otpOut), .otpMode(otpMode),
    .spiFast(spiFast), .spiRateMhz(spiRateMhz),
    .rateStrapOut(rateStrapOut), .rateStrapOe(rateStrapOe),
    .rateStrapPull(rateStrapPull));

  rom_model #(.SIG(SIG)) rom (
    .sys_clk(sys_clk), .rst_n(rst_n), .romReq(romReq), .romAddr(romAddr),
    .present(romPresent), .lat(romLat), .romValid(romValid),
    .romData(romData));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Record every probe address as the design launches it
  always @(posedge sys_clk)
    if (romReq === 1'b1)
      addrs.push_back(romAddr);

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failCount++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic step();
    @(posedge sys_clk);
    #10;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      failCount++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Each request task lets an edge pass first so a pulse is never re-raised
  task automatic usb(input cmd_t op, input logic [7:0] arg);
    step();
    usbCmd = {1'b1, op, arg};
    step();
    usbCmd = '0;
  endtask

  task automatic smb(input logic [7:0] a, input logic [7:0] d);
    step();
    smbWr = {1'b1, a, d};
    step();
    smbWr = '0;
  endtask

  task automatic sotp(input cmd_t op, input logic [7:0] arg);
    step();
    smbOtpCmd = {1'b1, op, arg};
    step();
    smbOtpCmd = '0;
  endtask

  task automatic do_reset(input logic strap, input logic present,
                          input logic smbOn, input logic [3:0] l);
    int i;
    rst_n = 1'b0;
    // Bench drives the strap level onto the pad; it flips it three cycles after release
    rateStrapIn = strap;
    romPresent = present;
    smbusPresent = smbOn;
    romLat = l;
    repeat (8) step();
    check(rateStrapOe, 1'b0);
    check(rateStrapPull, 1'b1);
    check(vendorMsgEnabled, 1'b1);
    addrs.delete();
    rst_n = 1'b1;
    repeat (3) step();
    rateStrapIn = ~strap;
    for (i = 0; i < 300 && cfgSource === SRC_NONE; i++)
      step();
    check(i < 300, 1'b1);
    step();
  endtask

  initial
  begin
    {rst_n, smbusPresent, hubAttached, suspend} = '0;
    {rateStrapIn, rateStrapFunc, romPresent, romLat} = '0;
    {smbWr, smbOtpCmd, usbCmd} = '0;
    failCount = 0;
    nChecks = 0;
    cycles = 0;
    do_reset(1'b0, 1'b1, 1'b0, 4'h3);
    check(cfgSource, SRC_SPI);
    check(cfgDone, 1'b1);
    check(execExternal, 1'b1);
    check(execStartAddr, 16'h0000);
    check(addrs.size(), 4);
    foreach (addrs[i])
      check(addrs[i], 16'hfffa + i);
    check({spiFast, spiRateMhz}, {1'b0, 7'h1e});
    sotp(CMD_OTP_MODE, 8'h02);
    check(otpOut.valid, 1'b0);
    usb(CMD_EC_ON, 8'h00);
    check(ecEnabled, 1'b1);
    usb(CMD_EC_OFF, 8'h00);
    check(ecEnabled, 1'b0);
    usb(CMD_SRES_ON, 8'h00);
    check(specialResume, 1'b1);
    usb(CMD_SRES_OFF, 8'h00);
    check(specialResume, 1'b0);
    usb(CMD_HUB_RESET, 8'h00);
    check(hubResetReq, 1'b1);
    step();
    check(hubResetReq, 1'b0);
    usb(CMD_I2C_WRITE, 8'h55);
    check(i2cOut.valid, 1'b0);
    usb(CMD_I2C_ENTER, 8'h00);
    check(i2cPass, 1'b1);
    foreach (i2cOps[i])
    begin
      usb(i2cOps[i], 8'h55);
      check(i2cOut, {1'b1, i2cOps[i], 8'h55});
    end
    usb(CMD_I2C_LEAVE, 8'h00);
    check(i2cPass, 1'b0);
    usb(CMD_SPI_READ, 8'h3a);
    check(spiOut.valid, 1'b0);
    usb(CMD_SPI_ENTER, 8'h00);
    check(spiPass, 1'b1);
    usb(CMD_SPI_WRITE, 8'h3a);
    check(spiOut, {1'b1, CMD_SPI_WRITE, 8'h3a});
    usb(CMD_SPI_READ, 8'h3b);
    check(spiOut, {1'b1, CMD_SPI_READ, 8'h3b});
    usb(CMD_SPI_LEAVE, 8'h00);
    check(spiPass, 1'b0);
    foreach (otpOps[i])
    begin
      usb(otpOps[i], 8'h03);
      check(otpOut, {1'b1, otpOps[i], OTP_SINGLE});
    end
    check(otpMode, OTP_SINGLE);
    $display("test rom_source done");

    do_reset(1'b1, 1'b0, 1'b1, 4'h0);
    check(cfgSource, SRC_SMBUS);
    check(cfgDone, 1'b0);
    check({spiFast, spiRateMhz}, {1'b1, 7'h3c});
    smb(8'h10, 8'haa);
    check(extWr, {1'b1, 8'h10, 8'haa});
    hubAttached = 1'b1;
    smb(8'h11, 8'hbb);
    check(extWr.valid, 1'b0);
    hubAttached = 1'b0;
    for (int m = 0; m < 4; m++)
    begin
      sotp(CMD_OTP_MODE, 8'(m));
      check(otpMode, m);
      check(otpOut, {1'b1, CMD_OTP_MODE, 2'(m)});
    end
    // USB side forces single-ended even after SMBus picked another mode
    usb(CMD_OTP_MODE, 8'h03);
    check(otpOut, {1'b1, CMD_OTP_MODE, OTP_SINGLE});
    check(otpMode, OTP_SINGLE);
    // Host closes configuration with the end register
    smb(END_CFG_REG, 8'h00);
    check(cfgDone, 1'b1);
    smb(8'h12, 8'hcc);
    check(extWr.valid, 1'b0);
    suspend = 1'b1;
    repeat (2) step();
    check(rateStrapOe, 1'b0);
    suspend = 1'b0;
    $display("test smbus_source done");

    do_reset(1'b0, 1'b0, 1'b0, 4'h1);
    check(cfgSource, SRC_DEFAULT);
    check({cfgDone, execExternal}, 2'h2);
    rateStrapFunc = 1'b1;
    repeat (2) step();
    check({rateStrapOe, rateStrapOut}, 2'h3);
    suspend = 1'b1;
    repeat (2) step();
    check({rateStrapOe, rateStrapOut}, 2'h2);
    check(spiRateMhz, 7'h1e);
    $display("test default_source done");
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
